// >>> verilog/btm_map.svh
// Constants for the bus trigger mask matcher: field positions, sizes and reset values
`ifndef BTM_MAP_SVH
`define BTM_MAP_SVH

// Target address and data widths
`define BTM_ADDR_W 20
`define BTM_DATA_W 8

// Address trigger fields
`define BTM_NFIELD 3
`define BTM_FIELD_LOW 2'h0
`define BTM_FIELD_SECOND 2'h1
`define BTM_FIELD_UPPER 2'h2
`define BTM_LOW_LSB 0
`define BTM_SECOND_LSB 8
`define BTM_UPPER_LSB 16
`define BTM_UPPER_W 4

// Alternatives that may be ORed within one field
`define BTM_NALT 4
`define BTM_ALT_IDX_W 2

// Emulation memory: 64 KB in the emulation segment, enabled per 1 KB region
`define BTM_EMU_AW 16
`define BTM_REGION_SHIFT 10
`define BTM_NREGION 64
`define BTM_REGION_IDX_W 6
`define BTM_EMU_SEG 4'h0

// Block compare keeps A15..A19 of the second area
`define BTM_BLOCK_LSB 15

// Reset values
`define BTM_RST_BYTE 8'h00
`define BTM_RST_ADDR 20'h00000
`define BTM_RST_ALT 4'h0

`endif

// >>> verilog/btm_pkg.sv
// Types shared by the bus trigger mask matcher modules
package btm_pkg;

  // Comparison kind held by one alternative slot
  typedef enum logic [1:0] {
    BTM_CMP_VALUE = 2'h0,
    BTM_CMP_MASK = 2'h1,
    BTM_CMP_RANGE = 2'h2
  } btm_cmp_e;

  // Memory access requests
  typedef enum logic [2:0] {
    BTM_OP_STORE = 3'h0,
    BTM_OP_READ = 3'h1,
    BTM_OP_SEQ_STORE = 3'h2,
    BTM_OP_SET_REF = 3'h3,
    BTM_OP_BLOCK_CMP = 3'h4,
    BTM_OP_REGION_EN = 3'h5
  } btm_op_e;

  // Access sequencer states, one-hot
  typedef enum logic [3:0] {
    BTM_ST_IDLE = 4'h1,
    BTM_ST_ACCESS = 4'h2,
    BTM_ST_EMU_WAIT = 4'h4,
    BTM_ST_DBG_WAIT = 4'h8
  } btm_state_e;

endpackage

// >>> verilog/btm_field_match.sv
// One address trigger field: ORed alternative slots, each value, mask or range
`timescale 1ns/1ns
`include "btm_map.svh"
module btm_field_match (
  // Sampled field bits
  input wire logic [7:0] field_in,
  // Slot settings, one entry per alternative
  input wire logic [`BTM_NALT-1:0] slot_en_in,
  input wire logic [`BTM_NALT-1:0] slot_neg_in,
  input wire logic [2*`BTM_NALT-1:0] slot_cmp_in,
  input wire logic [8*`BTM_NALT-1:0] slot_a_in,
  input wire logic [8*`BTM_NALT-1:0] slot_b_in,
  // Field agrees with its settings
  output logic match_out
);
  import btm_pkg::*;

  logic [`BTM_NALT-1:0] slot_hit;

  // Per-slot comparison; for a mask slot a is the select and b the value
  genvar g;
  generate
    for (g = 0; g < `BTM_NALT; g = g + 1) begin : g_slot
      wire [7:0] a = slot_a_in[8*g +: 8];
      wire [7:0] b = slot_b_in[8*g +: 8];
      wire [1:0] kind = slot_cmp_in[2*g +: 2];
      wire hit_value = (field_in == a);
      wire hit_mask = (((field_in ^ b) & a) == 8'h00);
      wire hit_range = (field_in >= a) && (field_in <= b);
      wire raw = (kind == BTM_CMP_MASK) ? hit_mask :
                 (kind == BTM_CMP_RANGE) ? hit_range : hit_value;
      // Negation is never paired with a mask by the configuring side
      assign slot_hit[g] = slot_en_in[g] & (raw ^ slot_neg_in[g]);
    end
  endgenerate

  // Any enabled alternative satisfies the field; an unset field is don't-care
  assign match_out = (slot_en_in == `BTM_RST_ALT) ? 1'b1 : (|slot_hit);

endmodule

// >>> verilog/btm_emu_ram.sv
// Emulation memory with its per-region enable map
`timescale 1ns/1ns
`include "btm_map.svh"
module btm_emu_ram (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Region enable map update
  input wire logic map_set_in,
  input wire logic [`BTM_ADDR_W-1:0] map_addr_in,
  input wire logic map_val_in,
  // Lookup and access
  input wire logic [`BTM_ADDR_W-1:0] addr_in,
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  output logic hit_out,
  output logic [7:0] rdata_out
);

  logic [7:0] mem [0:(1<<`BTM_EMU_AW)-1];
  logic [`BTM_NREGION-1:0] region_en;

  // Region lookup; addresses outside the emulation segment never hit
  wire [`BTM_EMU_AW-1:0] emu_addr = addr_in[`BTM_EMU_AW-1:0];
  wire [`BTM_REGION_IDX_W-1:0] region_idx = addr_in[`BTM_EMU_AW-1:`BTM_REGION_SHIFT];
  wire [`BTM_REGION_IDX_W-1:0] map_idx = map_addr_in[`BTM_EMU_AW-1:`BTM_REGION_SHIFT];
  wire seg_ok = (addr_in[`BTM_ADDR_W-1:`BTM_EMU_AW] == `BTM_EMU_SEG);
  assign hit_out = seg_ok & region_en[region_idx];

  // Enable map clears at reset so nothing is emulated until software says so
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      region_en <= '0;
    end else if (map_set_in) begin
      region_en[map_idx] <= map_val_in;
    end
  end

  // Array has no reset; read data lags the address by one clock
  always_ff @(posedge ref_clk_in) begin
    if (we_in) begin
      mem[emu_addr] <= wdata_in;
    end
    rdata_out <= mem[emu_addr];
  end

endmodule

// >>> verilog/btm_top.sv
// Bus trigger mask matcher: target bus sampling, address trigger and memory access routing
`timescale 1ns/1ns
`include "btm_map.svh"
module btm_top (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Target bus pins
  input wire logic bus_strobe_in,
  input wire logic [`BTM_ADDR_W-1:0] bus_addr_in,
  input wire logic [`BTM_DATA_W-1:0] bus_data_in,
  // Trigger configuration
  input wire logic cfg_wr_in,
  input wire logic cfg_clear_in,
  input wire logic [1:0] cfg_field_in,
  input wire logic [`BTM_ALT_IDX_W-1:0] cfg_slot_in,
  input wire logic cfg_en_in,
  input wire logic cfg_neg_in,
  input wire btm_pkg::btm_cmp_e cfg_cmp_in,
  input wire logic [7:0] cfg_a_in,
  input wire logic [7:0] cfg_b_in,
  // Trigger result
  output logic trigger_out,
  output logic cycle_out,
  output logic [`BTM_ADDR_W-1:0] cap_addr_out,
  output logic [`BTM_DATA_W-1:0] cap_data_out,
  // Memory access requests
  input wire logic req_valid_in,
  input wire btm_pkg::btm_op_e req_op_in,
  input wire logic [`BTM_ADDR_W-1:0] req_addr_in,
  input wire logic [`BTM_ADDR_W-1:0] req_end_in,
  input wire logic [`BTM_ADDR_W-1:0] req_cmp_in,
  input wire logic [7:0] req_data_in,
  output logic req_ready_out,
  // Memory access answers
  output logic resp_valid_out,
  output logic resp_err_out,
  output logic resp_mismatch_out,
  output logic resp_last_out,
  output logic [`BTM_ADDR_W-1:0] resp_addr_out,
  output logic [7:0] resp_data_out,
  output logic [7:0] resp_other_out,
  output logic [`BTM_ADDR_W-1:0] ref_addr_out,
  // Debugger path to target RAM
  input wire logic dbg_control_in,
  input wire logic dbg_ack_in,
  input wire logic [7:0] dbg_rdata_in,
  output logic dbg_req_out,
  output logic dbg_write_out,
  output logic [`BTM_ADDR_W-1:0] dbg_addr_out,
  output logic [7:0] dbg_wdata_out
);
  import btm_pkg::*;

  // Pin synchronisers; the third strobe stage only feeds the edge detector
  logic strobe_s1, strobe_s2, strobe_s3;
  logic [`BTM_ADDR_W-1:0] addr_s1, addr_s2;
  logic [`BTM_DATA_W-1:0] data_s1, data_s2;

  // Trigger settings per field and slot
  logic [`BTM_NALT-1:0] slot_en [0:`BTM_NFIELD-1];
  logic [`BTM_NALT-1:0] slot_neg [0:`BTM_NFIELD-1];
  logic [2*`BTM_NALT-1:0] slot_cmp [0:`BTM_NFIELD-1];
  logic [8*`BTM_NALT-1:0] slot_a [0:`BTM_NFIELD-1];
  logic [8*`BTM_NALT-1:0] slot_b [0:`BTM_NFIELD-1];
  logic [`BTM_NFIELD-1:0] field_match;

  // Access sequencer state
  btm_state_e st;
  btm_op_e op;
  logic [`BTM_ADDR_W-1:0] cur_addr;
  logic [`BTM_ADDR_W-1:0] end_addr;
  logic [`BTM_ADDR_W-1:0] cmp_addr;
  logic [7:0] wdata;
  logic [7:0] byte_a;
  logic phase_b;

  // Strobe, address and data all pass the same two synchroniser stages; the strobe also has a third
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      addr_s1 <= `BTM_RST_ADDR;
      addr_s2 <= `BTM_RST_ADDR;
      data_s1 <= `BTM_RST_BYTE;
      data_s2 <= `BTM_RST_BYTE;
    end else begin
      strobe_s1 <= bus_strobe_in;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      addr_s1 <= bus_addr_in;
      addr_s2 <= addr_s1;
      data_s1 <= bus_data_in;
      data_s2 <= data_s1;
    end
  end

  // Bus need only hold address and data stable where the strobe edge is sampled; both lag two stages like it
  wire cycle_edge = strobe_s2 & ~strobe_s3;

  // Field inputs cut from the sampled address; upper segment is zero extended
  wire [7:0] low_field = addr_s2[`BTM_SECOND_LSB-1:`BTM_LOW_LSB];
  wire [7:0] second_field = addr_s2[`BTM_UPPER_LSB-1:`BTM_SECOND_LSB];
  wire [7:0] upper_field = {4'h0, addr_s2[`BTM_ADDR_W-1:`BTM_UPPER_LSB]};

  // Settings are written one slot at a time; a clear drops every slot
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int f = 0; f < `BTM_NFIELD; f++) begin
        slot_en[f] <= `BTM_RST_ALT;
        slot_neg[f] <= `BTM_RST_ALT;
        slot_cmp[f] <= '0;
        slot_a[f] <= '0;
        slot_b[f] <= '0;
      end
    end else if (cfg_clear_in) begin
      for (int f = 0; f < `BTM_NFIELD; f++) begin
        slot_en[f] <= `BTM_RST_ALT;
      end
    end else if (cfg_wr_in && (cfg_field_in < 2'(`BTM_NFIELD))) begin
      slot_en[cfg_field_in][cfg_slot_in] <= cfg_en_in;
      slot_neg[cfg_field_in][cfg_slot_in] <= cfg_neg_in;
      slot_cmp[cfg_field_in][2*cfg_slot_in +: 2] <= cfg_cmp_in;
      slot_a[cfg_field_in][8*cfg_slot_in +: 8] <= cfg_a_in;
      slot_b[cfg_field_in][8*cfg_slot_in +: 8] <= cfg_b_in;
    end
  end

  // One comparator per address field
  btm_field_match u_low (
    .field_in(low_field),
    .slot_en_in(slot_en[0]),
    .slot_neg_in(slot_neg[0]),
    .slot_cmp_in(slot_cmp[0]),
    .slot_a_in(slot_a[0]),
    .slot_b_in(slot_b[0]),
    .match_out(field_match[0])
  );

  btm_field_match u_second (
    .field_in(second_field),
    .slot_en_in(slot_en[1]),
    .slot_neg_in(slot_neg[1]),
    .slot_cmp_in(slot_cmp[1]),
    .slot_a_in(slot_a[1]),
    .slot_b_in(slot_b[1]),
    .match_out(field_match[1])
  );

  btm_field_match u_upper (
    .field_in(upper_field),
    .slot_en_in(slot_en[2]),
    .slot_neg_in(slot_neg[2]),
    .slot_cmp_in(slot_cmp[2]),
    .slot_a_in(slot_a[2]),
    .slot_b_in(slot_b[2]),
    .match_out(field_match[2])
  );

  // Trigger needs all fields at once in the same bus cycle
  wire all_match = &field_match;

  // Capture and trigger outputs, one pulse per bus cycle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trigger_out <= 1'b0;
      cycle_out <= 1'b0;
      cap_addr_out <= `BTM_RST_ADDR;
      cap_data_out <= `BTM_RST_BYTE;
    end else begin
      cycle_out <= cycle_edge;
      trigger_out <= cycle_edge & all_match;
      if (cycle_edge) begin
        cap_addr_out <= addr_s2;
        cap_data_out <= data_s2;
      end
    end
  end

  // Access decode
  wire st_idle = (st == BTM_ST_IDLE);
  wire st_access = (st == BTM_ST_ACCESS);
  wire st_emu_wait = (st == BTM_ST_EMU_WAIT);
  wire st_dbg_wait = (st == BTM_ST_DBG_WAIT);
  wire is_write = (op == BTM_OP_STORE) || (op == BTM_OP_SEQ_STORE);
  wire is_cmp = (op == BTM_OP_BLOCK_CMP);
  wire req_take = st_idle & req_valid_in;
  wire req_store = (req_op_in == BTM_OP_STORE) || (req_op_in == BTM_OP_SEQ_STORE);
  wire req_mem = req_store || (req_op_in == BTM_OP_READ) || (req_op_in == BTM_OP_BLOCK_CMP);
  wire [`BTM_ADDR_W-1:0] start_addr = (req_op_in == BTM_OP_SEQ_STORE) ? ref_addr_out : req_addr_in;
  wire [`BTM_ADDR_W-1:0] acc_addr = (is_cmp && phase_b) ? cmp_addr : cur_addr;
  wire emu_hit;
  wire [7:0] emu_rdata;
  wire emu_we = st_access & is_write & emu_hit;
  wire rd_done = st_emu_wait | (st_dbg_wait & dbg_ack_in & ~is_write);
  wire [7:0] rd_byte = st_emu_wait ? emu_rdata : dbg_rdata_in;
  wire cmp_last = (cur_addr == end_addr);
  // Second area moves only in its low 15 bits, so it stays in its 32K block
  wire [`BTM_ADDR_W-1:0] cmp_next = {cmp_addr[`BTM_ADDR_W-1:`BTM_BLOCK_LSB],
                                     cmp_addr[`BTM_BLOCK_LSB-1:0] + 15'h0001};

  // Emulation memory and its enable map
  btm_emu_ram u_emu (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .map_set_in(req_take && (req_op_in == BTM_OP_REGION_EN)),
    .map_addr_in(req_addr_in),
    .map_val_in(req_data_in[0]),
    .addr_in(acc_addr),
    .we_in(emu_we),
    .wdata_in(wdata),
    .hit_out(emu_hit),
    .rdata_out(emu_rdata)
  );

  // Access sequencer: route each byte to emulation memory or the debugger
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= BTM_ST_IDLE;
      op <= BTM_OP_READ;
      cur_addr <= `BTM_RST_ADDR;
      end_addr <= `BTM_RST_ADDR;
      cmp_addr <= `BTM_RST_ADDR;
      wdata <= `BTM_RST_BYTE;
      byte_a <= `BTM_RST_BYTE;
      phase_b <= 1'b0;
      req_ready_out <= 1'b1;
      ref_addr_out <= `BTM_RST_ADDR;
      resp_valid_out <= 1'b0;
      resp_err_out <= 1'b0;
      resp_mismatch_out <= 1'b0;
      resp_last_out <= 1'b0;
      resp_addr_out <= `BTM_RST_ADDR;
      resp_data_out <= `BTM_RST_BYTE;
      resp_other_out <= `BTM_RST_BYTE;
      dbg_req_out <= 1'b0;
      dbg_write_out <= 1'b0;
      dbg_addr_out <= `BTM_RST_ADDR;
      dbg_wdata_out <= `BTM_RST_BYTE;
    end else begin
      resp_valid_out <= 1'b0;
      case (st)
        BTM_ST_IDLE: begin
          if (req_valid_in) begin
            op <= req_op_in;
            cur_addr <= start_addr;
            end_addr <= req_end_in;
            cmp_addr <= req_cmp_in;
            wdata <= req_data_in;
            phase_b <= 1'b0;
            if (req_mem) begin
              st <= BTM_ST_ACCESS;
              req_ready_out <= 1'b0;
            end else begin
              // Reference load and region enable finish at once
              if (req_op_in == BTM_OP_SET_REF) begin
                ref_addr_out <= req_addr_in;
              end
              resp_valid_out <= 1'b1;
              resp_err_out <= 1'b0;
              resp_mismatch_out <= 1'b0;
              resp_last_out <= 1'b1;
              resp_addr_out <= req_addr_in;
              resp_data_out <= req_data_in;
            end
          end
        end
        BTM_ST_ACCESS: begin
          if (emu_hit) begin
            if (is_write) begin
              // Emulated byte is written this clock
              st <= BTM_ST_IDLE;
              req_ready_out <= 1'b1;
              resp_valid_out <= 1'b1;
              resp_err_out <= 1'b0;
              resp_mismatch_out <= 1'b0;
              resp_last_out <= 1'b1;
              resp_addr_out <= cur_addr;
              resp_data_out <= wdata;
              if (op == BTM_OP_SEQ_STORE) begin
                ref_addr_out <= cur_addr + 20'h00001;
              end
            end else begin
              st <= BTM_ST_EMU_WAIT;
            end
          end else if (dbg_control_in) begin
            st <= BTM_ST_DBG_WAIT;
            dbg_req_out <= 1'b1;
            dbg_write_out <= is_write;
            dbg_addr_out <= acc_addr;
            dbg_wdata_out <= wdata;
          end else begin
            // Target RAM is out of reach without the debugger
            st <= BTM_ST_IDLE;
            req_ready_out <= 1'b1;
            resp_valid_out <= 1'b1;
            resp_err_out <= 1'b1;
            resp_mismatch_out <= 1'b0;
            resp_last_out <= 1'b1;
            resp_addr_out <= acc_addr;
            resp_data_out <= wdata;
          end
        end
        BTM_ST_EMU_WAIT, BTM_ST_DBG_WAIT: begin
          if (st_dbg_wait && dbg_ack_in) begin
            dbg_req_out <= 1'b0;
          end
          if (st_dbg_wait && dbg_ack_in && is_write) begin
            st <= BTM_ST_IDLE;
            req_ready_out <= 1'b1;
            resp_valid_out <= 1'b1;
            resp_err_out <= 1'b0;
            resp_mismatch_out <= 1'b0;
            resp_last_out <= 1'b1;
            resp_addr_out <= cur_addr;
            resp_data_out <= wdata;
            if (op == BTM_OP_SEQ_STORE) begin
              ref_addr_out <= cur_addr + 20'h00001;
            end
          end else if (rd_done && !is_cmp) begin
            st <= BTM_ST_IDLE;
            req_ready_out <= 1'b1;
            resp_valid_out <= 1'b1;
            resp_err_out <= 1'b0;
            resp_mismatch_out <= 1'b0;
            resp_last_out <= 1'b1;
            resp_addr_out <= cur_addr;
            resp_data_out <= rd_byte;
          end else if (rd_done && !phase_b) begin
            byte_a <= rd_byte;
            phase_b <= 1'b1;
            st <= BTM_ST_ACCESS;
          end else if (rd_done) begin
            // Each discrepancy is reported; the final answer closes the walk
            resp_valid_out <= (rd_byte != byte_a) || cmp_last;
            resp_err_out <= 1'b0;
            resp_mismatch_out <= (rd_byte != byte_a);
            resp_last_out <= cmp_last;
            resp_addr_out <= cur_addr;
            resp_data_out <= byte_a;
            resp_other_out <= rd_byte;
            phase_b <= 1'b0;
            if (cmp_last) begin
              st <= BTM_ST_IDLE;
              req_ready_out <= 1'b1;
            end else begin
              cur_addr <= cur_addr + 20'h00001;
              cmp_addr <= cmp_next;
              st <= BTM_ST_ACCESS;
            end
          end
        end
        default: begin
          st <= BTM_ST_IDLE;
          req_ready_out <= 1'b1;
          dbg_req_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

// >>> bench/btm_top_assertions.sv
// Concurrent checks on the bus trigger mask matcher ports
`timescale 1ns/1ns
`include "btm_map.svh"
module btm_chk (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Trigger side
  input wire logic trigger_out,
  input wire logic cycle_out,
  input wire logic [`BTM_ADDR_W-1:0] cap_addr_out,
  // Request side
  input wire logic req_valid_in,
  input wire btm_pkg::btm_op_e req_op_in,
  input wire logic req_ready_out,
  input wire logic resp_valid_out,
  input wire logic resp_err_out,
  input wire logic resp_last_out,
  input wire logic [`BTM_ADDR_W-1:0] ref_addr_out,
  // Debugger side
  input wire logic dbg_control_in,
  input wire logic dbg_ack_in,
  input wire logic dbg_req_out,
  input wire logic dbg_write_out,
  input wire logic [`BTM_ADDR_W-1:0] dbg_addr_out
);
  import btm_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // Opcode of the request in flight, needed to judge its answer
  btm_op_e op_q;
  wire take = req_valid_in && req_ready_out;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      op_q <= BTM_OP_STORE;
    else if (take)
      op_q <= req_op_in;
  end
  sequence s_store_noctl;
    take && req_op_in == BTM_OP_STORE && !dbg_control_in;
  endsequence
  sequence s_done;
    resp_valid_out && resp_last_out;
  endsequence
  property p_trig;
    trigger_out |-> cycle_out;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger outside a bus cycle");
  property p_cycle;
    cycle_out |=> !cycle_out;
  endproperty
  a_cycle: assert property (p_cycle) else $error("bus cycle pulse too long");
  property p_cap;
    !cycle_out |-> $stable(cap_addr_out);
  endproperty
  a_cap: assert property (p_cap) else $error("capture moved outside a bus cycle");
  property p_store;
    s_store_noctl |-> ##2 s_done;
  endproperty
  a_store: assert property (p_store) else $error("store answer late");
  // Error flag holds after its answer, so only judge it while the answer stands
  property p_err;
    resp_valid_out && resp_err_out |-> s_done;
  endproperty
  a_err: assert property (p_err) else $error("refusal not a final answer");
  property p_hold;
    dbg_req_out && !dbg_ack_in |=> dbg_req_out && $stable(dbg_addr_out);
  endproperty
  a_hold: assert property (p_hold) else $error("debugger request dropped early");
  property p_wr;
    dbg_req_out && dbg_write_out |-> dbg_control_in;
  endproperty
  a_wr: assert property (p_wr) else $error("target write without control");
  property p_ref;
    resp_valid_out && op_q == BTM_OP_SEQ_STORE && !resp_err_out |-> ref_addr_out == $past(ref_addr_out) + 20'h00001;
  endproperty
  a_ref: assert property (p_ref) else $error("reference address not advanced");
  property p_ready;
    $rose(req_ready_out) |-> s_done;
  endproperty
  a_ready: assert property (p_ready) else $error("ready back without answer");
endmodule
bind btm_top btm_chk u_chk (.*);

// >>> bench/btm_target_model.sv
// Target bus and debugger model facing the matcher
`timescale 1ns/1ns
module btm_target_model (
  // Clock and answer delay
  input wire logic ref_clk_in,
  input wire logic [3:0] lat_in,
  // Target bus pins
  output logic bus_strobe_out,
  output logic [19:0] bus_addr_out,
  output logic [7:0] bus_data_out,
  // Debugger path
  input wire logic dbg_req_in,
  input wire logic dbg_write_in,
  input wire logic [19:0] dbg_addr_in,
  input wire logic [7:0] dbg_wdata_in,
  output logic dbg_ack_out,
  output logic [7:0] dbg_rdata_out
);
  logic [7:0] ram [0:255];
  logic [3:0] wait_n = 4'h0;
  initial begin
    bus_strobe_out = 1'b0;
    bus_addr_out = 20'h00000;
    bus_data_out = 8'h00;
    dbg_ack_out = 1'b0;
    dbg_rdata_out = 8'h00;
  end
  // One bus cycle; lines inverted after release so stale values never match
  task automatic cyc(input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    bus_addr_out = a;
    bus_data_out = d;
    bus_strobe_out = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    bus_strobe_out = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    bus_addr_out = ~a;
    bus_data_out = ~d;
  endtask
  // Debugger answers after lat_in clocks; read data is garbage outside ack
  always @(posedge ref_clk_in) begin
    #1;
    if (dbg_ack_out) begin
      dbg_ack_out = 1'b0;
      dbg_rdata_out = ~dbg_rdata_out;
    end else if (dbg_req_in === 1'b1 && wait_n == lat_in) begin
      wait_n = 4'h0;
      dbg_ack_out = 1'b1;
      if (dbg_write_in)
        ram[dbg_addr_in[7:0]] = dbg_wdata_in;
      dbg_rdata_out = ram[dbg_addr_in[7:0]];
    end else if (dbg_req_in === 1'b1)
      wait_n = wait_n + 4'h1;
  end
endmodule

// >>> bench/btm_top_tb_top.sv
// Self-checking testbench for the bus trigger mask matcher
`timescale 1ns/1ns
module btm_top_tb_top import btm_pkg::*;;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic bus_strobe_in, dbg_ack_in, trigger_out, cycle_out, req_ready_out, resp_valid_out;
  logic resp_err_out, resp_mismatch_out, resp_last_out, dbg_req_out, dbg_write_out, t_seen, r_err;
  logic [19:0] bus_addr_in, cap_addr_out, resp_addr_out, ref_addr_out, dbg_addr_out, a_seen;
  logic [7:0] bus_data_in, dbg_rdata_in, cap_data_out, resp_data_out, resp_other_out, dbg_wdata_out, d_seen, r_data;
  logic cfg_wr_in = 1'b0, cfg_clear_in = 1'b0, cfg_en_in = 1'b0, cfg_neg_in = 1'b0;
  logic req_valid_in = 1'b0, dbg_control_in = 1'b0;
  logic [1:0] cfg_field_in = 2'h0, cfg_slot_in = 2'h0;
  logic [7:0] cfg_a_in = 8'h00, cfg_b_in = 8'h00, req_data_in = 8'h00;
  logic [19:0] req_addr_in = 20'h00000, req_end_in = 20'h00000, req_cmp_in = 20'h00000;
  logic [3:0] lat = 4'h0;
  btm_cmp_e cfg_cmp_in = BTM_CMP_VALUE;
  btm_op_e req_op_in = BTM_OP_STORE;
  int n_mismatch = 0, n_checks = 0, n_cyc = 0;
  btm_top uut (.*);
  btm_target_model tgt (.ref_clk_in(ref_clk_in), .lat_in(lat), .bus_strobe_out(bus_strobe_in),
    .bus_addr_out(bus_addr_in), .bus_data_out(bus_data_in), .dbg_req_in(dbg_req_out),
    .dbg_write_in(dbg_write_out), .dbg_addr_in(dbg_addr_out), .dbg_wdata_in(dbg_wdata_out),
    .dbg_ack_out(dbg_ack_in), .dbg_rdata_out(dbg_rdata_in));
  always #2 ref_clk_in = ~ref_clk_in;
  // Latch what each bus cycle pulse shows, away from the clock edge
  always @(negedge ref_clk_in) begin
    if (cycle_out === 1'b1) begin
      n_cyc++;
      t_seen = trigger_out;
      a_seen = cap_addr_out;
      d_seen = cap_data_out;
    end
  end
  task chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Write one slot; a clear uses the same two-edge pulse
  task cfg(input logic [1:0] f, s, input logic clr, input btm_cmp_e c, input logic [7:0] a, b);
    @(posedge ref_clk_in);
    #1;
    cfg_field_in = f;
    cfg_slot_in = s;
    cfg_cmp_in = c;
    cfg_a_in = a;
    cfg_b_in = b;
    cfg_en_in = 1'b1;
    cfg_wr_in = !clr;
    cfg_clear_in = clr;
    @(posedge ref_clk_in);
    #1;
    {cfg_wr_in, cfg_clear_in} = 2'b00;
  endtask
  task bus(input logic [19:0] a, input logic [7:0] d, input logic exp);
    int n0;
    n0 = n_cyc;
    tgt.cyc(a, d);
    chk(20'(n_cyc - n0), 20'h00001);
    chk(a_seen, a);
    chk(d_seen, d);
    chk(t_seen, exp);
  endtask
  // One request, sent once ready and held for one clock, answer sampled while it stands
  task req(input btm_op_e op, input logic [19:0] a, input logic [7:0] d);
    int i;
    for (i = 0; i < 40 && req_ready_out !== 1'b1; i++) @(negedge ref_clk_in);
    @(posedge ref_clk_in);
    #1;
    req_op_in = op;
    {req_addr_in, req_data_in, req_valid_in} = {a, d, 1'b1};
    @(posedge ref_clk_in);
    #1;
    req_valid_in = 1'b0;
    for (i = 0; i < 40 && resp_valid_out !== 1'b1; i++) @(negedge ref_clk_in);
    if (i == 40)
      n_mismatch++;
    r_err = resp_err_out;
    r_data = resp_data_out;
  endtask
  task t_reset;
    chk(req_ready_out, 1'b1);
    chk(trigger_out, 1'b0);
    chk(ref_addr_out, 20'h00000);
  endtask
  task t_alt;
    cfg(0, 0, 1, BTM_CMP_VALUE, 8'h00, 8'h00);
    cfg(1, 0, 0, BTM_CMP_VALUE, 8'h12, 8'h00);
    cfg(0, 0, 0, BTM_CMP_VALUE, 8'h34, 8'h00);
    cfg(0, 1, 0, BTM_CMP_VALUE, 8'h10, 8'h00);
    cfg(0, 2, 0, BTM_CMP_VALUE, 8'h05, 8'h00);
    bus(20'h01234, 8'hA5, 1'b1);
    bus(20'h01210, 8'h5A, 1'b1);
    bus(20'hF1205, 8'h3C, 1'b1);
    bus(20'h01233, 8'hC3, 1'b0);
    bus(20'h01334, 8'h0F, 1'b0);
    cfg(2, 0, 0, BTM_CMP_VALUE, 8'h03, 8'h00);
    bus(20'hF1234, 8'hF0, 1'b0);
    bus(20'h31210, 8'h81, 1'b1);
  endtask
  task t_mask;
    logic [7:0] v [2];
    v = '{8'h01, 8'hFF};
    foreach (v[i]) begin
      cfg(0, 0, 1, BTM_CMP_VALUE, 8'h00, 8'h00);
      cfg(0, 0, 0, BTM_CMP_MASK, 8'h01, v[i]);
      bus(20'h00003, 8'h11, 1'b1);
      bus(20'h00002, 8'h22, 1'b0);
    end
    cfg(0, 0, 0, BTM_CMP_MASK, 8'hF0, 8'h00);
    bus(20'h0000F, 8'h33, 1'b1);
    bus(20'h0001F, 8'h44, 1'b0);
  endtask
  // Range and negated slots, each alone in its field
  task t_rng;
    cfg(0, 0, 1, BTM_CMP_VALUE, 8'h00, 8'h00);
    cfg(0, 0, 0, BTM_CMP_RANGE, 8'h20, 8'h2F);
    bus(20'h00020, 8'h55, 1'b1);
    bus(20'h00030, 8'h66, 1'b0);
    cfg_neg_in = 1'b1;
    cfg(1, 0, 0, BTM_CMP_VALUE, 8'h00, 8'h00);
    cfg_neg_in = 1'b0;
    bus(20'h0012F, 8'h77, 1'b1);
    bus(20'h0002F, 8'h88, 1'b0);
  endtask
  task t_mem;
    req(BTM_OP_REGION_EN, 20'h00400, 8'h01);
    req(BTM_OP_STORE, 20'h00410, 8'hA5);
    chk(r_err, 1'b0);
    req(BTM_OP_READ, 20'h00410, 8'h00);
    chk(r_data, 8'hA5);
    req(BTM_OP_STORE, 20'h08010, 8'h5A);
    chk(r_err, 1'b1);
    @(posedge ref_clk_in);
    #1;
    dbg_control_in = 1'b1;
    lat = 4'h5;
    req(BTM_OP_STORE, 20'h08010, 8'h5A);
    chk(r_err, 1'b0);
    chk(tgt.ram[8'h10], 8'h5A);
    lat = 4'h0;
    req(BTM_OP_READ, 20'h08010, 8'h00);
    chk(r_data, 8'h5A);
  endtask
  task t_seq;
    req(BTM_OP_SET_REF, 20'h00420, 8'h00);
    req(BTM_OP_SEQ_STORE, 20'h00000, 8'h11);
    req(BTM_OP_SEQ_STORE, 20'h00000, 8'h22);
    chk(ref_addr_out, 20'h00422);
    req(BTM_OP_READ, 20'h00421, 8'h00);
    chk(r_data, 8'h22);
    req(BTM_OP_READ, 20'h00420, 8'h00);
    chk(r_data, 8'h11);
  endtask
  // Block compare: equal first byte stays silent, the last one differs
  task t_blk;
    req(BTM_OP_STORE, 20'h00430, 8'h11);
    req(BTM_OP_STORE, 20'h00431, 8'h33);
    @(posedge ref_clk_in);
    #1;
    req_end_in = 20'h00421;
    req_cmp_in = 20'h00430;
    req(BTM_OP_BLOCK_CMP, 20'h00420, 8'h00);
    chk(resp_mismatch_out, 1'b1);
    chk(resp_last_out, 1'b1);
    chk(resp_addr_out, 20'h00421);
    chk(r_data, 8'h22);
    chk(resp_other_out, 8'h33);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk_in);
    #1;
    rstn_in = 1'b1;
    t_reset;
    t_alt;
    t_mask;
    t_rng;
    t_mem;
    t_seq;
    t_blk;
    end_sim;
  end
  // Watchdog well beyond the expected run
  initial begin
    #20000;
    n_mismatch++;
    end_sim;
  end
endmodule
